/* hw/srf_pkg.sv */
// Constants, register map and state type of the supply, reset and fault supervisor
package srf_pkg;

  // System clock
  localparam int SYS_CLK_PERIOD_NS = 40;

  // Missing external clock detection, longest time, rounded down
  localparam int CLK_MSS_NS = 10000;
  localparam int CLK_MSS_CYC = CLK_MSS_NS / SYS_CLK_PERIOD_NS;

  // Power-on-reset interval after a reset pin release, longest time, rounded down
  localparam int POR_PIN_NS = 100000;
  localparam int POR_PIN_CYC = POR_PIN_NS / SYS_CLK_PERIOD_NS;

  // Power-on-reset interval after an undervoltage, in external clock periods
  localparam int POR_UV_EDGES = 65536;

  // Counter width, large enough for either interval
  localparam int CNT_W = 17;
  localparam int GAP_W = 9;

  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_DIAG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_IDENT = 8'h02;

  // Diagnosis register fields
  localparam int DIAG_RST = 0;
  localparam int DIAG_PUMP_UV = 1;
  localparam int DIAG_PUMP_WARN = 2;
  localparam int DIAG_LOAD_UV = 3;
  localparam int DIAG_OVERVOLT = 5;
  localparam int DIAG_WD = 6;

  // Control register fields
  localparam int CTRL_WD_ON = 0;
  localparam int CTRL_EFM = 1;
  localparam int CTRL_CFM = 2;
  localparam int CTRL_CHREQ = 4;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  // Identity register: watchdog status in the top bit, arbitrary identity below
  localparam int IDENT_WD = 15;
  localparam logic [7:0] IDENT_DEFAULT = 8'h5a;

  // Channels
  localparam int NUM_CH = 2;

  // Asynchronous input bank positions
  localparam int SY_LOGIC_UV = 0;
  localparam int SY_ANALOG_UV = 1;
  localparam int SY_REF_UV = 2;
  localparam int SY_LOAD_UV = 3;
  localparam int SY_PUMP_UV = 5;
  localparam int SY_PUMP_WARN = 6;
  localparam int SY_OVERVOLT = 7;
  localparam int SY_EXT_RST_N = 8;
  localparam int SY_ENABLE = 9;
  localparam int SY_EXT_CLK = 10;
  localparam int SY_W = 11;
  localparam logic [SY_W-1:0] SY_RESET = 11'h000;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_HELD,
    ST_POR_UV,
    ST_POR_PIN,
    ST_RUN,
    ST_WDFAULT
  } srf_state_t;

endpackage

/* hw/srf_sync_bank.sv */
// Two-stage synchroniser bank for asynchronous comparator and pin levels
`timescale 1ns/1ps
module srf_sync_bank #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Levels in and out
  srf_sync_if.bank sy
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // The first stage feeds only the second one
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= sy.raw;
      sync_reg <= meta_reg;
    end
  end

  assign sy.synced = sync_reg;

endmodule

/* hw/srf_sync_if.sv */
// Carrier between the supervisor and its input synchroniser bank
`timescale 1ns/1ps
interface srf_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport owner (
    output raw,
    input synced
  );

  modport bank (
    input raw,
    output synced
  );
endinterface

/* hw/supply_reset_fault_supervisor.sv */
// Supply, clock watchdog and charge-pump supervisor with reset sequencing and fault output
//
// What this block does
// - Load supply undervoltage: channel off, flag set
// - Core supply undervoltage holds internal reset
// - Clock loss resets only with watchdog on
// - Release reset after supplies good plus delay
// - Register access only after reset delay ends
// - Set reset flag on every reset exit
// - Diagnosis access clears reset flag
// - Pump undervoltage disables outputs, sets flag
// - Pump warning flag, operation continues
// - Sleep while any core supply low
// - Sleep exit runs full reset sequence
// - Enable low: channels off, masked fault
// - Load undervoltage: only that channel, masked
// - Overvoltage: channels off, fault, bus alive
// - Reset pin low: reset, fault, bus off
// - Watchdog fault: reads identity, writes ignored
// - Outputs off until watchdog enabled
// - Delay: 65536 clock edges or 0.1 ms
`timescale 1ns/1ps
module supply_reset_fault_supervisor #(
  parameter int POR_UV_EDGES = srf_pkg::POR_UV_EDGES,
  parameter logic [7:0] IDENT_VAL = srf_pkg::IDENT_DEFAULT
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Supply comparators, high means undervoltage
  input wire logic i_logic_supply_uv,
  input wire logic i_analog_supply_uv,
  input wire logic i_reference_supply_uv,
  input wire logic [srf_pkg::NUM_CH-1:0] i_load_supply_uv,
  // Charge pump and battery comparators
  input wire logic i_pump_undervolt,
  input wire logic i_pump_warning,
  input wire logic i_bat_overvolt,
  // Host pins
  input wire logic i_ext_reset_n,
  input wire logic i_enable,
  input wire logic i_ext_clk,
  // Register port
  input wire logic [srf_pkg::ADDR_W-1:0] i_addr,
  input wire logic [srf_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [srf_pkg::DATA_W-1:0] o_rdata,
  // Power stage gates
  output logic [srf_pkg::NUM_CH-1:0] o_chan_on,
  // Open-drain fault pin
  output logic o_fault_out_n_o,
  output logic o_fault_out_n_oe,
  // Status
  output logic o_sleep,
  output logic o_ready
);

  // Reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_n_int;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_int <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_int <= rst_meta_reg;
    end
  end

  // Asynchronous inputs
  srf_sync_if #(.W(srf_pkg::SY_W)) sy ();

  assign sy.raw[srf_pkg::SY_LOGIC_UV] = i_logic_supply_uv;
  assign sy.raw[srf_pkg::SY_ANALOG_UV] = i_analog_supply_uv;
  assign sy.raw[srf_pkg::SY_REF_UV] = i_reference_supply_uv;
  assign sy.raw[srf_pkg::SY_LOAD_UV +: srf_pkg::NUM_CH] = i_load_supply_uv;
  assign sy.raw[srf_pkg::SY_PUMP_UV] = i_pump_undervolt;
  assign sy.raw[srf_pkg::SY_PUMP_WARN] = i_pump_warning;
  assign sy.raw[srf_pkg::SY_OVERVOLT] = i_bat_overvolt;
  assign sy.raw[srf_pkg::SY_EXT_RST_N] = i_ext_reset_n;
  assign sy.raw[srf_pkg::SY_ENABLE] = i_enable;
  assign sy.raw[srf_pkg::SY_EXT_CLK] = i_ext_clk;

  srf_sync_bank #(
    .W(srf_pkg::SY_W),
    .RESET_VAL(srf_pkg::SY_RESET)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n_int),
    .sy(sy)
  );

  wire logic core_uv;
  wire logic [srf_pkg::NUM_CH-1:0] load_uv;
  wire logic pump_uv;
  wire logic pump_warn;
  wire logic overvolt;
  wire logic ext_rst_n_s;
  wire logic enable_s;
  wire logic ext_clk_s;

  assign core_uv = sy.synced[srf_pkg::SY_LOGIC_UV] | sy.synced[srf_pkg::SY_ANALOG_UV]
                 | sy.synced[srf_pkg::SY_REF_UV];
  assign load_uv = sy.synced[srf_pkg::SY_LOAD_UV +: srf_pkg::NUM_CH];
  assign pump_uv = sy.synced[srf_pkg::SY_PUMP_UV];
  assign pump_warn = sy.synced[srf_pkg::SY_PUMP_WARN];
  assign overvolt = sy.synced[srf_pkg::SY_OVERVOLT];
  assign ext_rst_n_s = sy.synced[srf_pkg::SY_EXT_RST_N];
  assign enable_s = sy.synced[srf_pkg::SY_ENABLE];
  assign ext_clk_s = sy.synced[srf_pkg::SY_EXT_CLK];

  // External clock edge detection and gap watchdog
  logic ext_clk_d_reg;
  logic [srf_pkg::GAP_W-1:0] gap_reg;
  logic [srf_pkg::GAP_W-1:0] gap_next;
  wire logic clk_edge;
  wire logic clk_missing;

  localparam logic [srf_pkg::GAP_W-1:0] GAP_LIMIT = srf_pkg::GAP_W'(srf_pkg::CLK_MSS_CYC);

  assign clk_edge = ext_clk_s & ~ext_clk_d_reg;
  assign clk_missing = (gap_reg >= GAP_LIMIT);
  assign gap_next = clk_edge ? '0 : (clk_missing ? gap_reg : gap_reg + 1'b1);

  always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ext_clk_d_reg <= 1'b0;
      gap_reg <= '0;
    end else begin
      ext_clk_d_reg <= ext_clk_s;
      gap_reg <= gap_next;
    end
  end

  // Reset sequencer
  srf_pkg::srf_state_t state_reg;
  srf_pkg::srf_state_t state_next;
  logic [srf_pkg::CNT_W-1:0] cnt_reg;
  logic [srf_pkg::CNT_W-1:0] cnt_next;
  logic uv_pend_reg;
  logic uv_pend_next;
  logic [srf_pkg::CTRL_W-1:0] ctrl_reg;

  localparam logic [srf_pkg::CNT_W-1:0] UV_LAST = srf_pkg::CNT_W'(POR_UV_EDGES - 1);
  localparam logic [srf_pkg::CNT_W-1:0] PIN_LAST = srf_pkg::CNT_W'(srf_pkg::POR_PIN_CYC - 1);

  wire logic wd_on;
  assign wd_on = ctrl_reg[srf_pkg::CTRL_WD_ON];

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    uv_pend_next = uv_pend_reg;
    if (core_uv) begin
      state_next = srf_pkg::ST_SLEEP;
      cnt_next = '0;
      uv_pend_next = 1'b1;
    end else if (!ext_rst_n_s) begin
      state_next = srf_pkg::ST_HELD;
      cnt_next = '0;
    end else begin
      case (state_reg)
        srf_pkg::ST_SLEEP,
        srf_pkg::ST_HELD: begin
          state_next = uv_pend_reg ? srf_pkg::ST_POR_UV : srf_pkg::ST_POR_PIN;
          cnt_next = '0;
        end
        srf_pkg::ST_POR_UV: begin
          if (clk_edge) begin
            if (cnt_reg == UV_LAST) begin
              state_next = srf_pkg::ST_RUN;
              uv_pend_next = 1'b0;
            end else begin
              cnt_next = cnt_reg + 1'b1;
            end
          end
        end
        srf_pkg::ST_POR_PIN: begin
          if (cnt_reg == PIN_LAST) begin
            state_next = srf_pkg::ST_RUN;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        srf_pkg::ST_RUN: begin
          if (wd_on && clk_missing) begin
            state_next = srf_pkg::ST_WDFAULT;
          end
        end
        srf_pkg::ST_WDFAULT: begin
          // Left only through the reset pin or a core supply undervoltage
          state_next = srf_pkg::ST_WDFAULT;
        end
        default: begin
          state_next = srf_pkg::ST_SLEEP;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_reg <= srf_pkg::ST_SLEEP;
      cnt_reg <= '0;
      uv_pend_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      uv_pend_reg <= uv_pend_next;
    end
  end

  wire logic running;
  wire logic wd_fault;
  wire logic in_reset;
  wire logic reset_exit;

  assign running = (state_reg == srf_pkg::ST_RUN);
  assign wd_fault = (state_reg == srf_pkg::ST_WDFAULT);
  assign in_reset = ~running;
  assign reset_exit = (state_next == srf_pkg::ST_RUN) & ~running;

  // Register port decode
  wire logic sel_diag;
  wire logic sel_ctrl;
  wire logic sel_ident;
  wire logic wr_ok;
  wire logic diag_access;

  assign sel_diag = (i_addr == srf_pkg::ADDR_DIAG);
  assign sel_ctrl = (i_addr == srf_pkg::ADDR_CTRL);
  assign sel_ident = (i_addr == srf_pkg::ADDR_IDENT);
  assign wr_ok = i_wr & running;
  assign diag_access = (i_wr | i_rd) & running & sel_diag;

  // Control register, cleared in every reset state so the watchdog starts off
  always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ctrl_reg <= srf_pkg::CTRL_RESET;
    end else if (in_reset) begin
      ctrl_reg <= srf_pkg::CTRL_RESET;
    end else if (wr_ok && sel_ctrl) begin
      ctrl_reg <= i_wdata[srf_pkg::CTRL_W-1:0];
    end
  end

  // Diagnosis flags: sticky, set wins over clear; event flags write one to clear, reset flag clears on any diagnosis access
  logic rst_flag_reg;
  logic pump_uv_flag_reg;
  logic pump_warn_flag_reg;
  logic ovv_flag_reg;
  logic [srf_pkg::NUM_CH-1:0] load_uv_flag_reg;
  logic wd_status_reg;
  wire logic [srf_pkg::DATA_W-1:0] w1c;

  assign w1c = (wr_ok && sel_diag) ? i_wdata : '0;

  always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rst_flag_reg <= 1'b0;
    end else if (reset_exit) begin
      rst_flag_reg <= 1'b1;
    end else if (diag_access) begin
      rst_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pump_uv_flag_reg <= 1'b0;
      pump_warn_flag_reg <= 1'b0;
      ovv_flag_reg <= 1'b0;
    end else if (in_reset) begin
      pump_uv_flag_reg <= 1'b0;
      pump_warn_flag_reg <= 1'b0;
      ovv_flag_reg <= 1'b0;
    end else begin
      pump_uv_flag_reg <= pump_uv | (pump_uv_flag_reg & ~w1c[srf_pkg::DIAG_PUMP_UV]);
      pump_warn_flag_reg <= pump_warn | (pump_warn_flag_reg & ~w1c[srf_pkg::DIAG_PUMP_WARN]);
      ovv_flag_reg <= overvolt | (ovv_flag_reg & ~w1c[srf_pkg::DIAG_OVERVOLT]);
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < srf_pkg::NUM_CH; ch++) begin : g_load_flag
      always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
          load_uv_flag_reg[ch] <= 1'b0;
        end else if (in_reset) begin
          load_uv_flag_reg[ch] <= 1'b0;
        end else begin
          load_uv_flag_reg[ch] <= load_uv[ch] | (load_uv_flag_reg[ch] & ~w1c[srf_pkg::DIAG_LOAD_UV + ch]);
        end
      end
    end
  endgenerate

  // Watchdog status survives the fault state and clears on the next reset
  always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      wd_status_reg <= 1'b0;
    end else if (state_reg == srf_pkg::ST_SLEEP || state_reg == srf_pkg::ST_HELD) begin
      wd_status_reg <= 1'b0;
    end else if (state_next == srf_pkg::ST_WDFAULT) begin
      wd_status_reg <= 1'b1;
    end
  end

  // Read data
  wire logic [srf_pkg::DATA_W-1:0] diag_word;
  wire logic [srf_pkg::DATA_W-1:0] ctrl_word;
  wire logic [srf_pkg::DATA_W-1:0] ident_word;
  wire logic [srf_pkg::DATA_W-1:0] rd_word;

  assign diag_word = ({{(srf_pkg::DATA_W-1){1'b0}}, rst_flag_reg} << srf_pkg::DIAG_RST)
                   | ({{(srf_pkg::DATA_W-1){1'b0}}, pump_uv_flag_reg} << srf_pkg::DIAG_PUMP_UV)
                   | ({{(srf_pkg::DATA_W-1){1'b0}}, pump_warn_flag_reg} << srf_pkg::DIAG_PUMP_WARN)
                   | ({{(srf_pkg::DATA_W-srf_pkg::NUM_CH){1'b0}}, load_uv_flag_reg} << srf_pkg::DIAG_LOAD_UV)
                   | ({{(srf_pkg::DATA_W-1){1'b0}}, ovv_flag_reg} << srf_pkg::DIAG_OVERVOLT)
                   | ({{(srf_pkg::DATA_W-1){1'b0}}, wd_status_reg} << srf_pkg::DIAG_WD);
  assign ctrl_word = {{(srf_pkg::DATA_W-srf_pkg::CTRL_W){1'b0}}, ctrl_reg};
  assign ident_word = {wd_status_reg, {(srf_pkg::DATA_W-9){1'b0}}, IDENT_VAL};

  // In the watchdog fault every answer is the identity word
  assign rd_word = wd_fault ? ident_word
                 : !running ? '0
                 : sel_diag ? diag_word
                 : sel_ctrl ? ctrl_word
                 : sel_ident ? ident_word
                 : '0;

  always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= rd_word;
    end else begin
      o_rdata <= '0;
    end
  end

  // Power stage gating
  wire logic common_ok;
  wire logic [srf_pkg::NUM_CH-1:0] chan_next;
  wire logic [srf_pkg::NUM_CH-1:0] chan_mask;
  wire logic fault_next;

  // Warning alone does not gate anything
  assign common_ok = running & wd_on & ~clk_missing & enable_s & ~pump_uv & ~overvolt;
  assign chan_next = {srf_pkg::NUM_CH{common_ok}} & ~load_uv
                   & ctrl_reg[srf_pkg::CTRL_CHREQ +: srf_pkg::NUM_CH];
  assign chan_mask = ctrl_reg[srf_pkg::CTRL_CFM +: srf_pkg::NUM_CH];

  assign fault_next = in_reset
                    | pump_uv
                    | overvolt
                    | (~enable_s & ctrl_reg[srf_pkg::CTRL_EFM])
                    | (|(load_uv & chan_mask));

  // Outputs come straight from flip-flops; the pin line itself is only ever pulled low
  always_ff @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      o_chan_on <= '0;
      o_fault_out_n_o <= 1'b0;
      o_fault_out_n_oe <= 1'b1;
      o_sleep <= 1'b1;
      o_ready <= 1'b0;
    end else begin
      o_chan_on <= chan_next;
      o_fault_out_n_o <= 1'b0;
      o_fault_out_n_oe <= fault_next;
      o_sleep <= (state_next == srf_pkg::ST_SLEEP);
      o_ready <= (state_next == srf_pkg::ST_RUN);
    end
  end

endmodule

/* sim/srf_checker.sv */
// Port-level assertions for the supply, reset and fault supervisor
`timescale 1ns/1ps
module srf_checker #(
  parameter int POR_UV_EDGES = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_logic_supply_uv,
  input wire logic i_analog_supply_uv,
  input wire logic i_reference_supply_uv,
  input wire logic [srf_pkg::NUM_CH-1:0] i_load_supply_uv,
  input wire logic i_pump_undervolt,
  input wire logic i_pump_warning,
  input wire logic i_bat_overvolt,
  input wire logic i_ext_reset_n,
  input wire logic i_enable,
  input wire logic i_ext_clk,
  input wire logic [srf_pkg::ADDR_W-1:0] i_addr,
  input wire logic [srf_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [srf_pkg::DATA_W-1:0] o_rdata,
  input wire logic [srf_pkg::NUM_CH-1:0] o_chan_on,
  input wire logic o_fault_out_n_o,
  input wire logic o_fault_out_n_oe,
  input wire logic o_sleep,
  input wire logic o_ready
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire core_uv = i_logic_supply_uv | i_analog_supply_uv | i_reference_supply_uv;
  wire good_now = !core_uv && i_ext_reset_n;
  logic [7:0] good_cnt;
  // Saturates, so only a lower bound on the quiet time before release is checked
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) good_cnt <= 8'h00;
    else if (!good_now) good_cnt <= 8'h00;
    else if (good_cnt != 8'hff) good_cnt <= good_cnt + 8'h01;
  end
  // Six cycles covers the two-flop synchroniser plus the output register
  sequence s_core_low; core_uv[*6]; endsequence
  sequence s_pin_low; (!i_ext_reset_n)[*6]; endsequence
  property p_sleep; s_core_low |=> o_sleep; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep on core undervoltage");
  property p_hold; o_sleep && $past(o_sleep) |-> !o_ready && o_chan_on == '0; endproperty
  a_hold: assert property (p_hold) else $error("logic active while in sleep");
  property p_pin; s_pin_low |=> !o_ready && o_fault_out_n_oe && o_chan_on == '0; endproperty
  a_pin: assert property (p_pin) else $error("reset pin low not honoured");
  // Four slow clock edges at the bench rate take at least this many cycles
  property p_rise; $rose(o_ready) |-> good_cnt > 8'd24; endproperty
  a_rise: assert property (p_rise) else $error("ready without reset interval");
  property p_pump; i_pump_undervolt[*6] |=> o_chan_on == '0 && o_fault_out_n_oe; endproperty
  a_pump: assert property (p_pump) else $error("pump undervoltage not handled");
  property p_ov; i_bat_overvolt[*6] |=> o_chan_on == '0 && o_fault_out_n_oe; endproperty
  a_ov: assert property (p_ov) else $error("overvoltage not handled");
  property p_en; (!i_enable)[*6] |=> o_chan_on == '0; endproperty
  a_en: assert property (p_en) else $error("channel on with enable low");
  property p_load; i_load_supply_uv[0][*6] |=> !o_chan_on[0]; endproperty
  a_load: assert property (p_load) else $error("channel on with load undervoltage");
  property p_rd; o_sleep && i_rd |=> o_rdata == 16'h0000; endproperty
  a_rd: assert property (p_rd) else $error("read answered during sleep");
  property p_drive; o_fault_out_n_oe |-> !o_fault_out_n_o; endproperty
  a_drive: assert property (p_drive) else $error("fault pin driven high");
  property p_chan; |o_chan_on |-> o_ready || $past(o_ready); endproperty
  a_chan: assert property (p_chan) else $error("channel on outside normal run");
endmodule

/* sim/srf_host_model.sv */
// Host microcontroller model: reset pin, enable pin and external clock
`timescale 1ns/1ps
module srf_host_model #(
  parameter int HALF = 5
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_req,
  input wire logic i_en_req,
  input wire logic i_clk_run,
  output logic o_ext_reset_n,
  output logic o_enable,
  output logic o_ext_clk
);
  int cnt = 0;
  initial begin
    o_ext_reset_n = 1'b0;
    o_enable = 1'b0;
    o_ext_clk = 1'b0;
  end
  always @(posedge i_sys_clk) begin
    o_ext_reset_n <= !i_rst_req;
    o_enable <= i_en_req;
    // A stopped clock sits at the pin's pull-down level
    if (!i_clk_run) begin
      cnt <= 0;
      o_ext_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      o_ext_clk <= !o_ext_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

/* sim/tb.sv */
// Self-checking bench for the supply, reset and fault supervisor
`timescale 1ns/1ps
module tb;
  localparam int UV_EDGES = 4;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] core_uv = 3'h0;
  logic [1:0] load_uv = 2'h0;
  logic pump_uv = 1'b0;
  logic pump_warn = 1'b0;
  logic ovolt = 1'b0;
  logic rst_req = 1'b0;
  logic en_req = 1'b1;
  logic clk_run = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext_reset_n, enable, ext_clk, flt_o, flt_oe, sleep, ready;
  logic [15:0] rdata;
  logic [1:0] chan_on;
  int num_errors = 0;
  int n_compared = 0;
  // The open-drain data bit rides along and must always read low
  wire [15:0] st = {10'h000, flt_o, sleep, chan_on, flt_oe, ready};
  always #20 i_sys_clk = ~i_sys_clk;
  srf_host_model host (.i_sys_clk(i_sys_clk), .i_rst_req(rst_req), .i_en_req(en_req), .i_clk_run(clk_run),
    .o_ext_reset_n(ext_reset_n), .o_enable(enable), .o_ext_clk(ext_clk));
  // Identity value is arbitrary
  supply_reset_fault_supervisor #(.POR_UV_EDGES(UV_EDGES), .IDENT_VAL(8'h3c)) uut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_logic_supply_uv(core_uv[0]),
    .i_analog_supply_uv(core_uv[1]), .i_reference_supply_uv(core_uv[2]), .i_load_supply_uv(load_uv),
    .i_pump_undervolt(pump_uv), .i_pump_warning(pump_warn), .i_bat_overvolt(ovolt),
    .i_ext_reset_n(ext_reset_n), .i_enable(enable), .i_ext_clk(ext_clk), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_chan_on(chan_on), .o_fault_out_n_o(flt_o),
    .o_fault_out_n_oe(flt_oe), .o_sleep(sleep), .o_ready(ready));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic settle;
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wait_ready(input int lim);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < lim) begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    chk({15'h0000, ready}, 16'h0001);
  endtask
  task automatic t_boot;
    rd_reg(srf_pkg::ADDR_CTRL, 16'h0000);
    wr_reg(srf_pkg::ADDR_CTRL, 16'h0031);
    wait_ready(400);
    rd_reg(srf_pkg::ADDR_DIAG, 16'h0001);
    rd_reg(srf_pkg::ADDR_DIAG, 16'h0000);
    rd_reg(srf_pkg::ADDR_CTRL, 16'h0000);
    rd_reg(8'h07, 16'h0000);
    rd_reg(srf_pkg::ADDR_IDENT, 16'h003c);
    wr_reg(srf_pkg::ADDR_CTRL, 16'h0030);
    settle;
    chk(st, 16'h0001);
    wr_reg(srf_pkg::ADDR_CTRL, 16'h0031);
    settle;
    chk(st, 16'h000d);
  endtask
  task automatic t_load;
    for (int c = 0; c < 2; c++) begin
      @(posedge i_sys_clk);
      load_uv <= 2'h1 << c;
      settle;
      chk(st, (c == 0) ? 16'h0009 : 16'h0005);
      rd_reg(srf_pkg::ADDR_DIAG, 16'h0008 << c);
      wr_reg(srf_pkg::ADDR_CTRL, 16'h0031 | (16'h0004 << c));
      settle;
      chk(st, (c == 0) ? 16'h000b : 16'h0007);
      @(posedge i_sys_clk);
      load_uv <= 2'h0;
      wr_reg(srf_pkg::ADDR_CTRL, 16'h0031);
      wr_reg(srf_pkg::ADDR_DIAG, 16'h0018);
      rd_reg(srf_pkg::ADDR_DIAG, 16'h0000);
    end
  endtask
  task automatic t_enable;
    @(posedge i_sys_clk);
    en_req <= 1'b0;
    settle;
    chk(st, 16'h0001);
    wr_reg(srf_pkg::ADDR_CTRL, 16'h0033);
    settle;
    chk(st, 16'h0003);
    @(posedge i_sys_clk);
    en_req <= 1'b1;
    settle;
    chk(st, 16'h000d);
  endtask
  task automatic t_pump_ov;
    @(posedge i_sys_clk);
    pump_warn <= 1'b1;
    settle;
    chk(st, 16'h000d);
    rd_reg(srf_pkg::ADDR_DIAG, 16'h0004);
    @(posedge i_sys_clk);
    pump_uv <= 1'b1;
    settle;
    chk(st, 16'h0003);
    rd_reg(srf_pkg::ADDR_DIAG, 16'h0006);
    @(posedge i_sys_clk);
    pump_uv <= 1'b0;
    pump_warn <= 1'b0;
    ovolt <= 1'b1;
    settle;
    chk(st, 16'h0003);
    wr_reg(srf_pkg::ADDR_DIAG, 16'h0006);
    rd_reg(srf_pkg::ADDR_DIAG, 16'h0020);
    @(posedge i_sys_clk);
    ovolt <= 1'b0;
    settle;
    chk(st, 16'h000d);
  endtask
  task automatic t_wd;
    wr_reg(srf_pkg::ADDR_CTRL, 16'h0030);
    @(posedge i_sys_clk);
    clk_run <= 1'b0;
    repeat (300) @(posedge i_sys_clk);
    #1;
    chk(st, 16'h0001);
    wr_reg(srf_pkg::ADDR_CTRL, 16'h0031);
    repeat (300) @(posedge i_sys_clk);
    #1;
    chk(st, 16'h0002);
    rd_reg(srf_pkg::ADDR_DIAG, 16'h803c);
    wr_reg(srf_pkg::ADDR_CTRL, 16'h0031);
    rd_reg(8'h07, 16'h803c);
    @(posedge i_sys_clk);
    clk_run <= 1'b1;
    rst_req <= 1'b1;
    settle;
    chk(st, 16'h0002);
    rd_reg(srf_pkg::ADDR_DIAG, 16'h0000);
    @(posedge i_sys_clk);
    rst_req <= 1'b0;
    repeat (2400) @(posedge i_sys_clk);
    #1;
    chk(st, 16'h0002);
    wait_ready(400);
    rd_reg(srf_pkg::ADDR_DIAG, 16'h0001);
  endtask
  task automatic t_sleep;
    for (int k = 0; k < 3; k++) begin
      wr_reg(srf_pkg::ADDR_CTRL, 16'h0031);
      @(posedge i_sys_clk);
      core_uv <= 3'h1 << k;
      settle;
      chk(st, 16'h0012);
      rd_reg(srf_pkg::ADDR_DIAG, 16'h0000);
      @(posedge i_sys_clk);
      core_uv <= 3'h0;
      repeat (10) @(posedge i_sys_clk);
      #1;
      chk(st, 16'h0002);
      wait_ready(400);
      rd_reg(srf_pkg::ADDR_DIAG, 16'h0001);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_boot;
    t_load;
    t_enable;
    t_pump_ov;
    t_wd;
    t_sleep;
    complete_run;
  end
  // The full run needs about 3500 cycles
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    num_errors++;
    complete_run;
  end
endmodule
bind supply_reset_fault_supervisor srf_checker #(.POR_UV_EDGES(POR_UV_EDGES)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_logic_supply_uv(i_logic_supply_uv),
  .i_analog_supply_uv(i_analog_supply_uv), .i_reference_supply_uv(i_reference_supply_uv),
  .i_load_supply_uv(i_load_supply_uv), .i_pump_undervolt(i_pump_undervolt), .i_pump_warning(i_pump_warning),
  .i_bat_overvolt(i_bat_overvolt), .i_ext_reset_n(i_ext_reset_n), .i_enable(i_enable), .i_ext_clk(i_ext_clk),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_chan_on(o_chan_on),
  .o_fault_out_n_o(o_fault_out_n_o), .o_fault_out_n_oe(o_fault_out_n_oe), .o_sleep(o_sleep), .o_ready(o_ready));
